/* File: rtl/cvt_addr_top.sv */
`default_nettype none

module cvt_addr_top #(
    parameter int DIM_W = 14,
    parameter int LVL_W = 4,
    parameter int CRD_W = 24,
    parameter int ADDR_W = 32,
    parameter int PITCH_W = 18,
    parameter int BPT_W = 6
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // request from the sampling engine
    input wire logic req_valid,
    input wire cvt_pkg::cvt_surf_e req_surf,
    input wire cvt_pkg::cvt_fmt_e req_fmt,
    input wire logic [DIM_W-1:0] req_width,
    input wire logic [DIM_W-1:0] req_height,
    input wire logic [DIM_W-1:0] req_depth,
    input wire logic [LVL_W-1:0] req_level,
    input wire logic [DIM_W-1:0] req_plane,
    input wire logic [DIM_W-1:0] req_u,
    input wire logic [DIM_W-1:0] req_v,
    input wire logic [ADDR_W-1:0] req_base,
    input wire logic [PITCH_W-1:0] req_pitch,
    input wire logic [BPT_W-1:0] req_bpt_half,
    // answer
    output logic rsp_valid,
    output logic [ADDR_W-1:0] rsp_addr,
    output logic [CRD_W-1:0] rsp_x,
    output logic [CRD_W-1:0] rsp_y,
    output logic rsp_keep,
    // translation path
    input wire logic xlat_rsp_valid,
    input wire logic xlat_rsp_unmapped,
    output logic xlat_err
);
    localparam int NUM_LVL = 1 << LVL_W;

    ////////////////////////////////////////////////////////////////////////
    // stage 1: request capture

    logic s1_valid_ff, nxt_s1_valid;
    cvt_pkg::cvt_surf_e s1_surf_ff, nxt_s1_surf;
    cvt_pkg::cvt_fmt_e s1_fmt_ff, nxt_s1_fmt;
    logic [DIM_W-1:0] s1_width_ff, nxt_s1_width;
    logic [DIM_W-1:0] s1_height_ff, nxt_s1_height;
    logic [DIM_W-1:0] s1_depth_ff, nxt_s1_depth;
    logic [LVL_W-1:0] s1_level_ff, nxt_s1_level;
    logic [DIM_W-1:0] s1_plane_ff, nxt_s1_plane;
    logic [DIM_W-1:0] s1_u_ff, nxt_s1_u;
    logic [DIM_W-1:0] s1_v_ff, nxt_s1_v;
    logic [ADDR_W-1:0] s1_base_ff, nxt_s1_base;
    logic [PITCH_W-1:0] s1_pitch_ff, nxt_s1_pitch;
    logic [BPT_W-1:0] s1_bpt_ff, nxt_s1_bpt;

    always_comb
    begin
        nxt_s1_valid = req_valid; // RULE22
        nxt_s1_surf = req_surf;
        nxt_s1_fmt = req_fmt;
        nxt_s1_width = req_width;
        nxt_s1_height = req_height;
        nxt_s1_depth = req_depth;
        nxt_s1_level = req_level;
        nxt_s1_plane = req_plane;
        nxt_s1_u = req_u;
        nxt_s1_v = req_v;
        nxt_s1_base = req_base;
        nxt_s1_pitch = req_pitch;
        nxt_s1_bpt = req_bpt_half;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_valid_ff <= 1'b0;
            s1_surf_ff <= cvt_pkg::cvt_surf_volume;
            s1_fmt_ff <= cvt_pkg::cvt_fmt_plain;
            s1_width_ff <= '0;
            s1_height_ff <= '0;
            s1_depth_ff <= '0;
            s1_level_ff <= '0;
            s1_plane_ff <= '0;
            s1_u_ff <= '0;
            s1_v_ff <= '0;
            s1_base_ff <= '0;
            s1_pitch_ff <= '0;
            s1_bpt_ff <= '0;
        end
        else
        begin
            s1_valid_ff <= nxt_s1_valid;
            s1_surf_ff <= nxt_s1_surf;
            s1_fmt_ff <= nxt_s1_fmt;
            s1_width_ff <= nxt_s1_width;
            s1_height_ff <= nxt_s1_height;
            s1_depth_ff <= nxt_s1_depth;
            s1_level_ff <= nxt_s1_level;
            s1_plane_ff <= nxt_s1_plane;
            s1_u_ff <= nxt_s1_u;
            s1_v_ff <= nxt_s1_v;
            s1_base_ff <= nxt_s1_base;
            s1_pitch_ff <= nxt_s1_pitch;
            s1_bpt_ff <= nxt_s1_bpt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-level sizes, one calculator per level so the row sum is one stage

    logic [DIM_W-1:0] lw_arr [NUM_LVL];
    logic [DIM_W-1:0] lh_arr [NUM_LVL];
    logic [DIM_W-1:0] ld_arr [NUM_LVL];
    logic [DIM_W:0] pw_arr [NUM_LVL];
    logic [DIM_W:0] ph_arr [NUM_LVL];
    logic [CRD_W-1:0] rows_arr [NUM_LVL];

    for (genvar k = 0; k < NUM_LVL; k++)
    begin : g_lvl
        cvt_lvl_if #(.DIM_W(DIM_W), .CRD_W(CRD_W)) lif ();
        assign lif.width = s1_width_ff;
        assign lif.height = s1_height_ff;
        assign lif.depth = s1_depth_ff;
        assign lif.fmt = s1_fmt_ff;
        assign lif.surf = s1_surf_ff;
        cvt_level_dims #(.DIM_W(DIM_W), .CRD_W(CRD_W), .LEVEL(k)) u_dims (
            .lvl(lif)
        );
        assign lw_arr[k] = lif.lw;
        assign lh_arr[k] = lif.lh;
        assign ld_arr[k] = lif.ld;
        assign pw_arr[k] = lif.pw;
        assign ph_arr[k] = lif.ph;
        assign rows_arr[k] = lif.rows;
    end

    ////////////////////////////////////////////////////////////////////////
    // stage 2: plane origin plus texel offset

    logic s2_valid_ff, nxt_s2_valid;
    logic [CRD_W-1:0] s2_x_ff, nxt_s2_x;
    logic [CRD_W-1:0] s2_y_ff, nxt_s2_y;
    logic s2_keep_ff, nxt_s2_keep;
    logic [ADDR_W-1:0] s2_base_ff, nxt_s2_base;
    logic [PITCH_W-1:0] s2_pitch_ff, nxt_s2_pitch;
    logic [BPT_W-1:0] s2_bpt_ff, nxt_s2_bpt;
    logic [1:0] s2_tsh_ff, nxt_s2_tsh;
    logic [CRD_W-1:0] row_sum;
    logic [31:0] col_mask;

    always_comb
    begin
        row_sum = '0;
        for (int k = 0; k < NUM_LVL; k++)
        begin
            if (k < int'(s1_level_ff))
                row_sum = row_sum + rows_arr[k]; // RULE8
        end
        col_mask = (32'h1 << s1_level_ff) - 32'h1;
        nxt_s2_valid = s1_valid_ff; // RULE22
        // plane q goes to column q mod 2^L, row q >> L of its level band
        nxt_s2_x = CRD_W'((32'(s1_plane_ff) & col_mask) * 32'(pw_arr[s1_level_ff])) +
                   CRD_W'(s1_u_ff); // RULE5 RULE8 RULE9
        nxt_s2_y = row_sum + CRD_W'((32'(s1_plane_ff) >> s1_level_ff) * 32'(ph_arr[s1_level_ff])) +
                   CRD_W'(s1_v_ff); // RULE8 RULE9
        // address still produced for the line fetch; only the use is masked
        nxt_s2_keep = (s1_u_ff < lw_arr[s1_level_ff]) && (s1_v_ff < lh_arr[s1_level_ff]) &&
                      (s1_plane_ff < ld_arr[s1_level_ff]); // RULE2 RULE10 RULE16
        nxt_s2_base = s1_base_ff;
        nxt_s2_pitch = s1_pitch_ff;
        nxt_s2_bpt = s1_bpt_ff;
        nxt_s2_tsh = cvt_pkg::t_shift(s1_fmt_ff);
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s2_valid_ff <= 1'b0;
            s2_x_ff <= '0;
            s2_y_ff <= '0;
            s2_keep_ff <= 1'b0;
            s2_base_ff <= '0;
            s2_pitch_ff <= '0;
            s2_bpt_ff <= '0;
            s2_tsh_ff <= cvt_pkg::T_SHIFT_PLAIN;
        end
        else
        begin
            s2_valid_ff <= nxt_s2_valid;
            s2_x_ff <= nxt_s2_x;
            s2_y_ff <= nxt_s2_y;
            s2_keep_ff <= nxt_s2_keep;
            s2_base_ff <= nxt_s2_base;
            s2_pitch_ff <= nxt_s2_pitch;
            s2_bpt_ff <= nxt_s2_bpt;
            s2_tsh_ff <= nxt_s2_tsh;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage 3: byte address, translation error

    logic rsp_valid_ff, nxt_rsp_valid;
    logic [ADDR_W-1:0] rsp_addr_ff, nxt_rsp_addr;
    logic [CRD_W-1:0] rsp_x_ff, nxt_rsp_x;
    logic [CRD_W-1:0] rsp_y_ff, nxt_rsp_y;
    logic rsp_keep_ff, nxt_rsp_keep;
    logic xlat_err_ff, nxt_xlat_err;
    logic [63:0] y_part;
    logic [63:0] x_part;

    always_comb
    begin
        // wide products so odd pitches and half-byte texels never wrap early
        y_part = (64'(s2_y_ff) * 64'(s2_pitch_ff)) >> s2_tsh_ff; // RULE21
        x_part = ((64'(s2_x_ff) * 64'(s2_bpt_ff)) << s2_tsh_ff) >> cvt_pkg::HALF_BYTE_SHIFT; // RULE21
        nxt_rsp_valid = s2_valid_ff; // RULE22
        nxt_rsp_addr = ADDR_W'(64'(s2_base_ff) + y_part + x_part); // RULE21
        nxt_rsp_x = s2_x_ff;
        nxt_rsp_y = s2_y_ff;
        nxt_rsp_keep = s2_valid_ff && s2_keep_ff; // RULE10 RULE16
        nxt_xlat_err = xlat_rsp_valid && xlat_rsp_unmapped; // RULE11
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rsp_valid_ff <= 1'b0;
            rsp_addr_ff <= '0;
            rsp_x_ff <= '0;
            rsp_y_ff <= '0;
            rsp_keep_ff <= 1'b0;
            xlat_err_ff <= 1'b0;
        end
        else
        begin
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_addr_ff <= nxt_rsp_addr;
            rsp_x_ff <= nxt_rsp_x;
            rsp_y_ff <= nxt_rsp_y;
            rsp_keep_ff <= nxt_rsp_keep;
            xlat_err_ff <= nxt_xlat_err;
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp_addr = rsp_addr_ff;
    assign rsp_x = rsp_x_ff;
    assign rsp_y = rsp_y_ff;
    assign rsp_keep = rsp_keep_ff;
    assign xlat_err = xlat_err_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    logic [CRD_W-1:0] chk_y0;
    logic [DIM_W-1:0] chk_d;
    assign chk_y0 = CRD_W'(32'(s1_plane_ff) * 32'(ph_arr[0]));
    assign chk_d = ((s1_depth_ff >> s1_level_ff) == '0) ? DIM_W'(1) : (s1_depth_ff >> s1_level_ff);

    AST_LATENCY: assert property (rsp_valid_ff == $past(req_valid, 3)) // RULE22
        else $error("response valid not three cycles after request");
    AST_CUBE_DEPTH: assert property (s1_valid_ff && s1_surf_ff == cvt_pkg::cvt_surf_cube
        |-> ld_arr[s1_level_ff] == DIM_W'(cvt_pkg::CUBE_FACES)) // RULE1
        else $error("cube plane count not six");
    AST_CUBE_FACE: assert property (req_valid && req_surf == cvt_pkg::cvt_surf_cube
        && req_plane > DIM_W'(cvt_pkg::FACE_NEG_Z) |-> ##3 rsp_valid_ff && !rsp_keep_ff) // RULE2
        else $error("cube face beyond minus z kept");
    AST_VOL_DEPTH: assert property (s1_valid_ff && s1_surf_ff == cvt_pkg::cvt_surf_volume
        |-> ld_arr[s1_level_ff] == chk_d) // RULE6
        else $error("volume plane count wrong");
    AST_CLAMP: assert property (s1_valid_ff |-> lw_arr[s1_level_ff] != '0 && lh_arr[s1_level_ff] != '0) // RULE6
        else $error("level size clamped to zero");
    AST_PAD: assert property (s1_valid_ff |-> (32'(pw_arr[s1_level_ff]) % 32'(cvt_pkg::align_w(s1_fmt_ff))) == 0
        && (32'(ph_arr[s1_level_ff]) % 32'(cvt_pkg::align_h(s1_fmt_ff))) == 0
        && pw_arr[s1_level_ff] >= (DIM_W + 1)'(lw_arr[s1_level_ff])) // RULE7
        else $error("padded level size not aligned");
    AST_COLUMN: assert property (s1_valid_ff && s1_level_ff == '0 && s1_u_ff == '0 && s1_v_ff == '0
        |=> s2_x_ff == '0 && s2_y_ff == $past(chk_y0)) // RULE5
        else $error("level zero plane not stacked in one column");
    AST_ORIGIN: assert property (req_valid && req_level == '0 && req_plane == '0 && req_u == '0
        && req_v == '0 |-> ##3 rsp_addr_ff == $past(req_base, 3)) // RULE21
        else $error("origin texel address not base");
    // a zero width still clamps to one texel, so u of zero is inside then
    AST_OUTSIDE: assert property (req_valid && req_level == '0 && req_u >= req_width && req_u != '0
        |-> ##3 !rsp_keep_ff) // RULE10
        else $error("texel right of surface kept");
    AST_XLAT: assert property (xlat_rsp_valid && xlat_rsp_unmapped |=> xlat_err_ff) // RULE11
        else $error("translation error not raised");
    AST_XLAT_QUIET: assert property (!(xlat_rsp_valid && xlat_rsp_unmapped) |=> !xlat_err_ff) // RULE11
        else $error("translation error without cause");

    COV_CUBE: cover property (req_valid && req_surf == cvt_pkg::cvt_surf_cube ##3 rsp_keep_ff);
    COV_VOL_MIP: cover property (req_valid && req_surf == cvt_pkg::cvt_surf_volume && req_level > '0 ##3 rsp_valid_ff);
    COV_DROP: cover property (rsp_valid_ff && !rsp_keep_ff);
    COV_XLAT: cover property (xlat_err_ff);

endmodule

`default_nettype wire

/* File: rtl/cvt_level_dims.sv */
`default_nettype none

module cvt_level_dims #(
    parameter int DIM_W = 14,
    parameter int CRD_W = 24,
    parameter int LEVEL = 0
) (
    cvt_lvl_if.calc lvl
);
    logic [31:0] ext_w;
    logic [31:0] ext_h;
    logic [31:0] ext_d;
    logic [31:0] am_w;
    logic [31:0] am_h;
    logic [31:0] ceil_d;

    always_comb
    begin
        ext_w = 32'(lvl.width) >> LEVEL;
        ext_h = 32'(lvl.height) >> LEVEL;
        ext_d = 32'(lvl.depth) >> LEVEL;
        if (ext_w == 32'h0)
            ext_w = 32'h1; // RULE6
        if (ext_h == 32'h0)
            ext_h = 32'h1; // RULE6
        if (ext_d == 32'h0)
            ext_d = 32'h1; // RULE6
        // cube faces never shrink, and storage for all six is always laid out
        if (lvl.surf == cvt_pkg::cvt_surf_cube)
            ext_d = cvt_pkg::CUBE_FACES; // RULE1 RULE3
        am_w = 32'(cvt_pkg::align_w(lvl.fmt)) - 32'h1;
        am_h = 32'(cvt_pkg::align_h(lvl.fmt)) - 32'h1;
        lvl.lw = DIM_W'(ext_w);
        lvl.lh = DIM_W'(ext_h);
        lvl.ld = DIM_W'(ext_d); // RULE7
        lvl.pw = (DIM_W + 1)'((ext_w + am_w) & ~am_w); // RULE7
        lvl.ph = (DIM_W + 1)'((ext_h + am_h) & ~am_h); // RULE7
        // rows of planes this level occupies: 2^LEVEL planes per row
        ceil_d = (ext_d + ((32'h1 << LEVEL) - 32'h1)) >> LEVEL; // RULE5
        lvl.rows = CRD_W'(ceil_d * 32'(lvl.ph)); // RULE8
    end

endmodule

`default_nettype wire

/* File: rtl/cvt_lvl_if.sv */
`default_nettype none

interface cvt_lvl_if #(
    parameter int DIM_W = 14,
    parameter int CRD_W = 24
);
    // surface description shared by every level
    logic [DIM_W-1:0] width;
    logic [DIM_W-1:0] height;
    logic [DIM_W-1:0] depth;
    cvt_pkg::cvt_fmt_e fmt;
    cvt_pkg::cvt_surf_e surf;
    // per-level results
    logic [DIM_W-1:0] lw;
    logic [DIM_W-1:0] lh;
    logic [DIM_W-1:0] ld;
    logic [DIM_W:0] pw;
    logic [DIM_W:0] ph;
    logic [CRD_W-1:0] rows;

    modport calc (
        input width, height, depth, fmt, surf,
        output lw, lh, ld, pw, ph, rows
    );
    modport user (
        output width, height, depth, fmt, surf,
        input lw, lh, ld, pw, ph, rows
    );
endinterface

`default_nettype wire

/* File: rtl/cvt_pkg.sv */
// Contract
// [RULE1] Cube surfaces use six planes at every mip level, never halved.
// [RULE2] Cube plane index is the face id, 0..5 for +X,-X,+Y,-Y,+Z,-Z.
// [RULE3] Cube layout is fixed regardless of mip count or enabled faces.
// [RULE4] Software gives all six cube faces one common texel format.
// [RULE5] Volume: level 0 planes stacked in one column, each level doubles row width.
// [RULE6] Level width, height, planes are base shifted by level, zero clamped to one.
// [RULE7] Level width and height padded to the alignment unit; plane count not padded.
// [RULE8] Origin x is (q mod 2^L)*w_L; y sums earlier level rows plus (q>>L)*h_L.
// [RULE9] Texels inside a level plane are located from its origin by 2D addressing.
// [RULE10] Fetched texels outside the surface never influence a sampling result.
// [RULE11] A fetch touching a page without valid translation raises a translation error.
// [RULE12] Software maps sampled surfaces extended to the alignment unit on right and bottom.
// [RULE13] Software maps buffers rounded to 256 elements plus 16 more bytes.
// [RULE14] Software reserves two extra valid rows below every cube surface.
// [RULE15] Compressed formats pad bottom to 8 rows but align mips with height 4.
// [RULE16] Out-of-surface pixels fetched in a cache request are not returned.
// [RULE17] Software adds one valid row below odd-height render or media surfaces.
// [RULE18] Field-mode access with row step 1 needs height padded to multiple of 4.
// [RULE19] Software sizes volume pitch to the widest row of padded level planes.
// [RULE20] Alignment unit 4x2 normally, 4x4 block-compressed, 8x4 eight-wide compressed.
// [RULE21] Address is base plus y*pitch/t plus x*bytes_per_texel*t.
// [RULE22] One request per clock, address with valid after a fixed pipeline latency.
`default_nettype none

package cvt_pkg;

    typedef enum logic [2:0] {
        cvt_fmt_plain  = 3'h0,
        cvt_fmt_yuv422 = 3'h1,
        cvt_fmt_bc1    = 3'h2,
        cvt_fmt_bc23   = 3'h3,
        cvt_fmt_bc45   = 3'h4,
        cvt_fmt_wide8  = 3'h5
    } cvt_fmt_e;

    typedef enum logic {
        cvt_surf_volume = 1'h0,
        cvt_surf_cube   = 1'h1
    } cvt_surf_e;

    localparam int unsigned CUBE_FACES = 6;
    localparam logic [2:0] FACE_POS_X = 3'h0;
    localparam logic [2:0] FACE_NEG_X = 3'h1;
    localparam logic [2:0] FACE_POS_Y = 3'h2;
    localparam logic [2:0] FACE_NEG_Y = 3'h3;
    localparam logic [2:0] FACE_POS_Z = 3'h4;
    localparam logic [2:0] FACE_NEG_Z = 3'h5;

    localparam logic [3:0] ALIGN_W_STD = 4'h4;
    localparam logic [3:0] ALIGN_H_STD = 4'h2;
    localparam logic [3:0] ALIGN_W_BC = 4'h4;
    localparam logic [3:0] ALIGN_H_BC = 4'h4;
    localparam logic [3:0] ALIGN_W_WIDE = 4'h8;
    localparam logic [3:0] ALIGN_H_WIDE = 4'h4;

    // rows per memory row as a shift: 4 -> 2, 1 -> 0
    localparam logic [1:0] T_SHIFT_PACKED = 2'h2;
    localparam logic [1:0] T_SHIFT_PLAIN = 2'h0;
    // bytes per texel arrive in half-byte units
    localparam int unsigned HALF_BYTE_SHIFT = 1;
    localparam int unsigned PIPE_LAT = 3;

    function automatic logic [3:0] align_w(input cvt_fmt_e fmt);
        if (fmt == cvt_fmt_wide8)
            return ALIGN_W_WIDE; // RULE20
        else if (fmt == cvt_fmt_bc1 || fmt == cvt_fmt_bc23 || fmt == cvt_fmt_bc45)
            return ALIGN_W_BC;
        else
            return ALIGN_W_STD;
    endfunction

    // bottom padding of 8 is software's job; mip alignment keeps 4
    function automatic logic [3:0] align_h(input cvt_fmt_e fmt);
        if (fmt == cvt_fmt_wide8)
            return ALIGN_H_WIDE; // RULE20
        else if (fmt == cvt_fmt_bc1 || fmt == cvt_fmt_bc23 || fmt == cvt_fmt_bc45)
            return ALIGN_H_BC; // RULE15
        else
            return ALIGN_H_STD;
    endfunction

    function automatic logic [1:0] t_shift(input cvt_fmt_e fmt);
        if (fmt == cvt_fmt_bc23 || fmt == cvt_fmt_wide8)
            return T_SHIFT_PACKED; // RULE21
        else
            return T_SHIFT_PLAIN;
    endfunction

endpackage

`default_nettype wire

/* File: tb/cvt_addr_top_test.sv */
`default_nettype none

module cvt_addr_top_test;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {longint addr; int x; int y; logic keep; int due;} cvt_exp_s;

    logic clock = 1'h0;
    logic arst_n = 1'h0;
    logic req_valid = 1'h0;
    cvt_pkg::cvt_surf_e req_surf = cvt_pkg::cvt_surf_volume;
    cvt_pkg::cvt_fmt_e req_fmt = cvt_pkg::cvt_fmt_plain;
    logic [13:0] req_width = 14'h0, req_height = 14'h0, req_depth = 14'h0, req_plane = 14'h0;
    logic [13:0] req_u = 14'h0, req_v = 14'h0;
    logic [3:0] req_level = 4'h0;
    logic [31:0] req_base = 32'h0;
    logic [17:0] req_pitch = 18'h0;
    logic [5:0] req_bpt_half = 6'h0;
    logic rsp_valid, rsp_keep, xlat_rsp_valid, xlat_rsp_unmapped, xlat_err;
    logic [31:0] rsp_addr;
    logic [23:0] rsp_x, rsp_y;
    // fully mapped, so any pad rows or tail bytes software owes are present
    logic [31:0] map_limit = 32'hffff_ffff;
    logic slow = 1'h0;
    logic hit_ff = 1'h0;
    int cyc = 0, n_mismatch = 0, total_checks = 0, n_xerr = 0;
    cvt_exp_s exp_q[$];
    cvt_exp_s e_m;

    always #25 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    cvt_addr_top dut_u (.clock(clock), .arst_n(arst_n), .req_valid(req_valid), .req_surf(req_surf),
        .req_fmt(req_fmt), .req_width(req_width), .req_height(req_height), .req_depth(req_depth),
        .req_level(req_level), .req_plane(req_plane), .req_u(req_u), .req_v(req_v), .req_base(req_base),
        .req_pitch(req_pitch), .req_bpt_half(req_bpt_half), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr),
        .rsp_x(rsp_x), .rsp_y(rsp_y), .rsp_keep(rsp_keep), .xlat_rsp_valid(xlat_rsp_valid),
        .xlat_rsp_unmapped(xlat_rsp_unmapped), .xlat_err(xlat_err));

    cvt_mem_xlat_model mem_u (.clock(clock), .arst_n(arst_n), .fetch_valid(rsp_valid), .fetch_addr(rsp_addr),
        .map_limit(map_limit), .slow(slow), .xlat_rsp_valid(xlat_rsp_valid),
        .xlat_rsp_unmapped(xlat_rsp_unmapped));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic fail(input string msg);
        n_mismatch++;
        $display("BAD %0t %s", $time, msg);
    endtask

    // bc1 and eight-wide 0.5 byte texels, everything else 4 bytes
    function automatic int bpt_of(input int fmt);
        return (fmt == 2 || fmt == 5) ? 1 : 8;
    endfunction

    function automatic cvt_exp_s expect_rsp(input int cube, input int fmt, input int w, input int h,
        input int d, input int l, input int q, input int u, input int v);
        int ai, aj, ts, wl, hl, dl, pw, ph, y0;
        cvt_exp_s r;
        ai = (fmt == 5) ? 8 : 4;
        aj = (fmt >= 2) ? 4 : 2;
        ts = (fmt == 3 || fmt == 5) ? 2 : 0;
        y0 = 0;
        for (int k = 0; k <= l; k++)
        begin
            wl = (w >> k) > 0 ? w >> k : 1;
            hl = (h >> k) > 0 ? h >> k : 1;
            dl = cube ? 6 : ((d >> k) > 0 ? d >> k : 1);
            pw = ((wl + ai - 1) / ai) * ai;
            ph = ((hl + aj - 1) / aj) * aj;
            if (k < l)
                y0 += ((dl + (1 << k) - 1) >> k) * ph;
        end
        r.x = (q % (1 << l)) * pw + u;
        r.y = y0 + (q >> l) * ph + v;
        r.addr = longint'(req_base) + ((longint'(r.y) * 1024) >> ts) + (((longint'(r.x) * bpt_of(fmt)) << ts) >> 1);
        r.keep = (u < wl && v < hl && q < dl);
        return r;
    endfunction

    task automatic send(input int cube, input int fmt, input int w, input int h, input int d, input int l,
        input int q, input int u, input int v);
        cvt_exp_s e;
        @(posedge clock);
        e = expect_rsp(cube, fmt, w, h, d, l, q, u, v);
        e.due = cyc + 4;
        req_valid <= 1'h1;
        req_surf <= cvt_pkg::cvt_surf_e'(cube);
        req_fmt <= cvt_pkg::cvt_fmt_e'(fmt);
        req_width <= 14'(w);
        req_height <= 14'(h);
        req_depth <= 14'(d);
        req_level <= 4'(l);
        req_plane <= 14'(q);
        req_u <= 14'(u);
        req_v <= 14'(v);
        req_pitch <= 18'h00400;
        req_bpt_half <= 6'(bpt_of(fmt));
        exp_q.push_back(e);
    endtask

    task automatic drain();
        @(posedge clock);
        req_valid <= 1'h0;
        for (int i = 0; i < 12 && exp_q.size() > 0; i++)
            @(posedge clock);
        if (exp_q.size() != 0)
            fail("response missing");
        repeat (6) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // responses are judged in order as they arrive
    always @(posedge clock)
    begin
        if (arst_n)
        begin
            if (rsp_valid === 1'h1)
            begin
                total_checks++;
                if (exp_q.size() == 0)
                    fail("unexpected response");
                else
                begin
                    e_m = exp_q.pop_front();
                    if (e_m.due != cyc || rsp_addr !== e_m.addr[31:0] || rsp_x !== 24'(e_m.x)
                        || rsp_y !== 24'(e_m.y) || rsp_keep !== e_m.keep)
                        fail($sformatf("rsp addr %h x %0d y %0d keep %b", rsp_addr, rsp_x, rsp_y, rsp_keep));
                end
            end
            else if (exp_q.size() > 0 && exp_q[0].due <= cyc)
            begin
                void'(exp_q.pop_front());
                fail("response late");
            end
            total_checks++;
            if (xlat_err !== hit_ff)
                fail("translation error pulse wrong");
            if (xlat_err === 1'h1)
                n_xerr++;
        end
        hit_ff <= arst_n & xlat_rsp_valid & xlat_rsp_unmapped;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_cube();
        req_base <= 32'h0004_0040;
        // one format per cube, face 6 lies outside
        for (int l = 0; l < 4; l++)
            for (int f = 0; f < 7; f++)
                send(1, l, 20, 20, 3, l, f, 1, 1);
        drain();
        $display("test cube done");
    endtask

    task automatic test_volume();
        slow <= 1'h1;
        req_base <= 32'h0010_0000;
        for (int f = 0; f < 6; f++)
            for (int l = 0; l < 5; l++)
                send(0, f, 37, 22, 5, l, (5 >> l) > 0 ? (5 >> l) - 1 : 0, 2, 1);
        drain();
        $display("test volume done");
    endtask

    task automatic test_outside();
        send(0, 0, 37, 22, 5, 1, 1, 17, 10);
        send(0, 0, 37, 22, 5, 1, 1, 18, 10);
        send(0, 0, 37, 22, 5, 1, 1, 17, 11);
        send(0, 0, 37, 22, 5, 1, 2, 17, 10);
        send(0, 0, 37, 22, 5, 0, 0, 0, 0);
        send(0, 0, 37, 22, 5, 0, 4, 0, 0);
        send(0, 0, 37, 22, 5, 0, 3, 37, 0);
        drain();
        $display("test outside done");
    endtask

    task automatic test_xlat();
        n_xerr = 0;
        slow <= 1'h0;
        map_limit <= 32'h0;
        repeat (3) send(0, 1, 8, 8, 1, 0, 0, 3, 3);
        drain();
        total_checks++;
        if (n_xerr != 3)
            fail($sformatf("prompt unmapped errors %0d", n_xerr));
        slow <= 1'h1;
        repeat (2) send(1, 4, 8, 8, 1, 1, 5, 0, 0);
        drain();
        map_limit <= 32'hffff_ffff;
        repeat (2) send(1, 4, 8, 8, 1, 1, 5, 0, 0);
        drain();
        total_checks++;
        if (n_xerr != 5)
            fail($sformatf("slow or mapped errors %0d", n_xerr));
        $display("test xlat done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge clock);
        arst_n <= 1'h1;
        test_cube();
        test_volume();
        test_outside();
        test_xlat();
        close_out();
    end

    // whole run is well under two hundred cycles
    initial
    begin
        #150000;
        fail("watchdog expired");
        close_out();
    end
endmodule

`default_nettype wire

/* File: tb/cvt_mem_xlat_model.sv */
`default_nettype none

module cvt_mem_xlat_model (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // fetches leaving the address block
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    // controls from the bench
    input wire logic [31:0] map_limit,
    input wire logic slow,
    // translation reply
    output logic xlat_rsp_valid,
    output logic xlat_rsp_unmapped
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] vld_ff;
    logic [2:0] nxt_vld;
    logic [2:0] unm_ff;
    logic [2:0] nxt_unm;
    logic tgl_ff;

    // pages below map_limit are the mapped, padded extent of the surface
    always_comb
    begin
        nxt_vld = {vld_ff[1:0], fetch_valid};
        nxt_unm = {unm_ff[1:0], fetch_addr >= map_limit};
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vld_ff <= 3'h0;
            unm_ff <= 3'h0;
            tgl_ff <= 1'h0;
        end
        else
        begin
            vld_ff <= nxt_vld;
            unm_ff <= nxt_unm;
            tgl_ff <= ~tgl_ff;
        end
    end

    // slow replies come two cycles later; only switch when idle
    assign xlat_rsp_valid = slow ? vld_ff[2] : vld_ff[0];
    // flag means nothing without valid, so it wanders
    assign xlat_rsp_unmapped = xlat_rsp_valid ? (slow ? unm_ff[2] : unm_ff[0]) : tgl_ff;
endmodule

`default_nettype wire
